// *** logic/smd_pkg.sv ***
// Purpose: Shared constants for the sync mode detection front end.
// Assumes: System clock of 40 MHz; counts are in measurement-clock ticks.
// Notes: Register indices are word addresses on the plain register port.
package smd_pkg;
  localparam int HCNT_W = 12;
  localparam int SEP_W = 8;
  localparam int DW = 16;
  localparam int AW = 2;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINES_PER_MEAS = 4;
  localparam int V_PRESCALE = 76;
  localparam logic [HCNT_W-1:0] H_STATIC = 12'hFF0;
  localparam logic [HCNT_W-1:0] H_PRESENT = 12'hFC0;
  localparam logic [SEP_W-1:0] SEP_MAX = 8'hFF;
  localparam logic [1:0] LINE_LAST = 2'(LINES_PER_MEAS - 1);
  localparam logic [3:0] UP_FILT_HIT = 4'hF;
  localparam logic [1:0] DN_FILT_HIT = 2'h3;
  localparam logic [5:0] POL_TO_POS_LINES = 6'h24;
  localparam logic [5:0] POL_TO_NEG_LINES = 6'h3C;
  localparam logic [5:0] H_SETTLE_LINES = 6'h3D;
  localparam logic [2:0] V_SETTLE_FRAMES = 3'h5;
  localparam int SEP_SHIFT = 4;
  localparam int VQ_SHIFT = 2;
  localparam logic [AW-1:0] REG_CTRL = 2'h0;
  localparam logic [AW-1:0] REG_STATUS = 2'h1;
  localparam logic [AW-1:0] REG_HPER = 2'h2;
  localparam logic [AW-1:0] REG_VPER = 2'h3;
  localparam int CTRL_V_SOURCE_SELECT = 0;
  localparam int CTRL_HALVE = 1;
  localparam int CTRL_ACK = 2;
  localparam int ST_HPOL = 0;
  localparam int ST_HPRES = 1;
  localparam int ST_VPOL = 2;
  localparam int ST_HREADY = 3;
  localparam int ST_VREADY = 4;
  localparam int ST_IRQ = 5;
  localparam int ST_HUPD = 6;
endpackage

// *** logic/smd_front_end.sv ***
// Purpose: Sync polarity correction, vertical sync separation and horizontal mode detection.
// Assumes: Sync pins are asynchronous; software uses the plain register port.
// Notes: Measurement clocks are one-cycle ticks on the system clock, not separate clocks.
//
// Contract
// - Horizontal measure clock is system clock, halved for the faster crystal choices.
// - Vertical measure clock is horizontal measure clock divided by seventy-six.
// - Horizontal period count spans four consecutive lines.
// - Horizontal sync is always turned positive-going using measured polarity.
// - Separation counter resets per processed pulse; samples sync at period/16.
// - Separation counter saturates at all ones, never wraps.
// - Separation counter restarts on every rising edge of processed horizontal sync.
// - Separated vertical sync follows composite level; low without composite sync.
// - Separated vertical sync lags the original window by a quarter line.
// - Period counter resets on each four-line pulse and at the upper threshold.
// - Period register loads only while the update enable is high.
// - Higher frequency needs fifteen comparisons in a 4-bit filter before interrupt.
// - Period count reaching 4080 means the horizontal input is static.
// - Lower, non-static frequency needs three comparisons in a 2-bit filter.
// - Change to static bypasses the filter and interrupts at once.
// - Presence flag set (no sync) when count hits upper threshold.
// - Presence flag cleared when measured count is below lower threshold.
// - Horizontal result usable only after about 61 lines or static detection.
// - Vertical polarity result valid only after five stable frames.
// - Source select picks vertical pin when clear, separated sync when set.
// - Horizontal polarity indicator reads 0 positive, 1 negative.
// - Polarity change interrupts after 36 lines to positive, 60 to negative.
// - Update enable high lets period and presence update; drops once stable.
module smd_front_end #(
  parameter int TOL = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsync_pin,
  input wire logic vsync_pin,
  input wire logic [smd_pkg::AW-1:0] addr,
  input wire logic [smd_pkg::DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [smd_pkg::DW-1:0] rdata,
  output logic hsync_out,
  output logic vsync_out,
  output logic vsep_out,
  output logic mode_irq
);
  localparam logic [6:0] V_DIV_LAST = 7'(smd_pkg::V_PRESCALE - 1);
  localparam logic [smd_pkg::HCNT_W-1:0] TOL_W = smd_pkg::HCNT_W'(TOL);

  // True when a exceeds b by more than the tolerance.
  function automatic logic beyond(input logic [smd_pkg::HCNT_W-1:0] a,
                                  input logic [smd_pkg::HCNT_W-1:0] b);
    beyond = (a > b) && ((a - b) > TOL_W);
  endfunction

  logic [1:0] sync1, sync2, sync3, pin_f;
  logic v_source_select, clk_halve;
  logic h_half;
  logic [6:0] vdiv;
  logic hs_d, hp_d, v_d;
  logic [1:0] line_cnt;
  logic [smd_pkg::HCNT_W-1:0] hcnt, hper, vcnt, vper;
  logic [smd_pkg::SEP_W-1:0] sep_cnt, hq_cnt;
  logic [3:0] up_cnt;
  logic [1:0] dn_cnt;
  logic [5:0] pol_cnt, settle_cnt;
  logic [2:0] v_frames;
  logic hpol, vpol, h_pres, h_update_enable, vsep, irq_pending, vpol_seen;

  wire [1:0] next_pin_f = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pin_f);
  wire hs_f = pin_f[0];
  wire vs_f = pin_f[1];
  // Horizontal tick every cycle, or every other cycle when halved.
  wire h_measure_clock = ~clk_halve | h_half;
  wire v_measure_clock = h_measure_clock && (vdiv == V_DIV_LAST);
  wire hsync_p = hs_f ^ hpol;
  wire hs_rise = hs_f & ~hs_d;
  wire h_rise = hsync_p & ~hp_d;
  wire hp4 = h_rise && (line_cnt == smd_pkg::LINE_LAST);
  wire static_hit = h_measure_clock && (hcnt == smd_pkg::H_STATIC);
  // A static input already reported and settled does not interrupt again.
  wire static_evt = static_hit && !(h_pres && (settle_cnt == smd_pkg::H_SETTLE_LINES));
  wire faster = hp4 && beyond(hper, hcnt);
  wire slower = hp4 && beyond(hcnt, hper);
  wire [3:0] next_up = up_cnt + 4'h1;
  wire [1:0] next_dn = dn_cnt + 2'h1;
  wire trig_up = faster && (next_up == smd_pkg::UP_FILT_HIT);
  wire trig_dn = slower && (next_dn == smd_pkg::DN_FILT_HIT);
  wire [smd_pkg::SEP_W-1:0] quarter = smd_pkg::SEP_W'(hper >> smd_pkg::SEP_SHIFT);
  wire sep_sample = h_measure_clock && !h_rise && (quarter != '0) && (sep_cnt == quarter);
  wire pol_sample = h_measure_clock && !hs_rise && (quarter != '0) && (hq_cnt == quarter);
  wire pol_diff = pol_sample && !h_pres && (hs_f != hpol);
  wire [5:0] next_pol = pol_cnt + 6'h1;
  wire [5:0] pol_need = hpol ? smd_pkg::POL_TO_POS_LINES : smd_pkg::POL_TO_NEG_LINES;
  wire pol_evt = pol_diff && (next_pol == pol_need);
  wire h_ready = (settle_cnt == smd_pkg::H_SETTLE_LINES);
  wire v_ready = (v_frames == smd_pkg::V_SETTLE_FRAMES);
  wire v_int = v_source_select ? vsep : vs_f;
  wire v_rise = v_int & ~v_d;
  wire [smd_pkg::HCNT_W-1:0] vq = vper >> smd_pkg::VQ_SHIFT;
  wire v_stable = !beyond(vcnt, vper) && !beyond(vper, vcnt);
  wire h_load = h_update_enable && (hp4 || static_hit);
  wire h_stable = !beyond(hcnt, hper) && !beyond(hper, hcnt);
  wire ack = wr && (addr == smd_pkg::REG_CTRL) && wdata[smd_pkg::CTRL_ACK];
  wire mode_evt = trig_up || trig_dn || static_evt || pol_evt;
  wire [smd_pkg::DW-1:0] status_word = smd_pkg::DW'({h_update_enable, irq_pending, v_ready,
                                                      h_ready, vpol, h_pres, hpol});
  wire [smd_pkg::DW-1:0] ctrl_word = smd_pkg::DW'({clk_halve, v_source_select});
  wire [smd_pkg::DW-1:0] read_mux =
    (addr == smd_pkg::REG_CTRL) ? ctrl_word :
    (addr == smd_pkg::REG_STATUS) ? status_word :
    (addr == smd_pkg::REG_HPER) ? smd_pkg::DW'(hper) : smd_pkg::DW'(vper);

  // Pins pass three flops; a level is taken once the last two agree.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_f <= '0;
    end
    else
    begin
      sync1 <= {vsync_pin, hsync_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_f <= next_pin_f;
    end
  end

  // Register port and measurement clock prescalers.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      v_source_select <= 1'b0;
      clk_halve <= 1'b0;
      rdata <= '0;
      h_half <= 1'b0;
      vdiv <= '0;
    end
    else
    begin
      if (wr && (addr == smd_pkg::REG_CTRL))
      begin
        v_source_select <= wdata[smd_pkg::CTRL_V_SOURCE_SELECT];
        clk_halve <= wdata[smd_pkg::CTRL_HALVE];
      end
      rdata <= rd ? read_mux : '0;
      h_half <= clk_halve & ~h_half;
      if (h_measure_clock)
        vdiv <= (vdiv == V_DIV_LAST) ? '0 : vdiv + 7'h1;
    end
  end

  // Edge history, line grouping and the four-line period counter.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hs_d <= 1'b0;
      hp_d <= 1'b0;
      v_d <= 1'b0;
      line_cnt <= '0;
      hcnt <= '0;
    end
    else
    begin
      hs_d <= hs_f;
      hp_d <= hsync_p;
      v_d <= v_int;
      if (h_rise)
        line_cnt <= line_cnt + 2'h1;
      if (hp4 || static_hit)
        hcnt <= '0;
      else if (h_measure_clock)
        hcnt <= hcnt + 12'h001;
    end
  end

  // Comparison filters, locked period, presence flag and update enable.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      up_cnt <= '0;
      dn_cnt <= '0;
      hper <= '0;
      h_pres <= 1'b1;
      h_update_enable <= 1'b0;
      settle_cnt <= '0;
    end
    else
    begin
      if (hp4)
      begin
        up_cnt <= (faster && !trig_up) ? next_up : '0;
        dn_cnt <= (slower && !trig_dn) ? next_dn : '0;
      end
      if (h_load)
        hper <= static_hit ? smd_pkg::H_STATIC : hcnt;
      if (static_hit)
        h_pres <= 1'b1;
      else if (h_load && (hcnt < smd_pkg::H_PRESENT))
        h_pres <= 1'b0;
      if (trig_up || trig_dn)
        h_update_enable <= 1'b1;
      else if (h_update_enable && hp4 && h_stable)
        h_update_enable <= 1'b0;
      // Settling restarts on every frequency change and ends after enough lines; a static input ends it at once.
      if (static_hit)
        settle_cnt <= smd_pkg::H_SETTLE_LINES;
      else if (trig_up || trig_dn)
        settle_cnt <= '0;
      else if (h_rise && !h_ready)
        settle_cnt <= settle_cnt + 6'h01;
    end
  end

  // Polarity measurement at a quarter line after each raw rising edge.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hq_cnt <= '0;
      pol_cnt <= '0;
      hpol <= 1'b0;
    end
    else
    begin
      if (hs_rise)
        hq_cnt <= '0;
      else if (h_measure_clock && (hq_cnt != smd_pkg::SEP_MAX))
        hq_cnt <= hq_cnt + 8'h01;
      if (pol_evt)
      begin
        hpol <= hs_f;
        pol_cnt <= '0;
      end
      else if (pol_diff)
        pol_cnt <= next_pol;
      else if (pol_sample)
        pol_cnt <= '0;
    end
  end

  // Vertical sync separation from the processed horizontal sync.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sep_cnt <= '0;
      vsep <= 1'b0;
    end
    else
    begin
      if (h_rise)
        sep_cnt <= '0;
      else if (h_measure_clock && (sep_cnt != smd_pkg::SEP_MAX))
        sep_cnt <= sep_cnt + 8'h01;
      if (h_pres)
        vsep <= 1'b0;
      else if (sep_sample)
        vsep <= hs_f;
    end
  end

  // Frame period, vertical polarity and frame settling.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vcnt <= '0;
      vper <= '0;
      v_frames <= '0;
      vpol_seen <= 1'b0;
      vpol <= 1'b0;
    end
    else
    begin
      if (v_rise)
      begin
        vcnt <= '0;
        vper <= vcnt;
        if (!v_stable)
          v_frames <= '0;
        else if (!v_ready)
          v_frames <= v_frames + 3'h1;
      end
      else if (v_measure_clock && (vcnt != smd_pkg::H_STATIC))
        vcnt <= vcnt + 12'h001;
      if (v_measure_clock && (vq != '0) && (vcnt == vq))
        vpol_seen <= v_int;
      if (v_ready)
        vpol <= vpol_seen;
    end
  end

  // Outputs and the pending mode change flag; a new event beats the ack.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      vsep_out <= 1'b0;
      irq_pending <= 1'b0;
      mode_irq <= 1'b0;
    end
    else
    begin
      hsync_out <= hsync_p;
      vsync_out <= v_int ^ vpol;
      vsep_out <= vsep;
      irq_pending <= mode_evt | (irq_pending & ~ack);
      mode_irq <= mode_evt | (irq_pending & ~ack);
    end
  end

  a_sep_saturate: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sep_cnt == smd_pkg::SEP_MAX) && !h_rise |=> (sep_cnt == smd_pkg::SEP_MAX))
    else $error("separation counter left its saturated value");

  a_hcnt_limit: assert property (
    @(posedge clk) disable iff (!arst_n)
    static_hit |=> (hcnt == '0) ##1 (hcnt <= 12'h001))
    else $error("period counter not cleared at upper threshold");

  a_hper_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    !h_update_enable |=> $stable(hper))
    else $error("period register changed without update enable");

  a_static_irq_now: assert property (
    @(posedge clk) disable iff (!arst_n)
    static_evt |=> mode_irq && h_pres && h_ready)
    else $error("static input did not raise interrupt at once");

  a_pres_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    h_update_enable && hp4 && (hcnt < smd_pkg::H_PRESENT) && !static_hit |=> !h_pres)
    else $error("presence flag not cleared below lower threshold");

  a_vsep_low: assert property (
    @(posedge clk) disable iff (!arst_n)
    h_pres |=> ##1 !vsep_out)
    else $error("separated sync not low without composite sync");

  a_v_source_select_route: assert property (
    @(posedge clk) disable iff (!arst_n)
    v_source_select && $stable(vpol) |=> (vsync_out == ($past(vsep) ^ $past(vpol))))
    else $error("vertical source select routed the wrong sync");

  a_hclk_half: assert property (
    @(posedge clk) disable iff (!arst_n)
    clk_halve && $past(clk_halve) && h_measure_clock |=> !h_measure_clock ##1 h_measure_clock)
    else $error("halved measure clock not every other cycle");

  a_vclk_spacing: assert property (
    @(posedge clk) disable iff (!arst_n)
    v_measure_clock |=> !v_measure_clock [*8])
    else $error("vertical measure clock ticks too often");

  a_irq_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    mode_irq && !ack |=> mode_irq)
    else $error("pending interrupt dropped without acknowledge");

  a_up_filter: assert property (
    @(posedge clk) disable iff (!arst_n)
    faster && (up_cnt != 4'hE) && !static_hit && !pol_evt && !trig_dn && !irq_pending
    |=> !mode_irq)
    else $error("higher frequency interrupted before fifteen counts");
endmodule

// *** testbench/smd_host_model.sv ***
// Purpose: Video host model that drives the horizontal and vertical sync pins.
// Assumes: Pulse width is one eighth of the line period.
// Notes: A stopped host parks the pin at its inactive level, so no edges appear.
module smd_host_model (
  input wire logic clk,
  input wire logic run,
  input wire logic neg,
  input wire logic [11:0] period,
  input wire logic vs_level,
  output logic hsync,
  output logic vsync
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cnt = 12'h000;
  always_ff @(posedge clk)
  begin
    if (!run || cnt >= period - 12'h001)
      cnt <= 12'h000;
    else
      cnt <= cnt + 12'h001;
  end
  assign hsync = neg ^ (run && cnt < (period >> 3));
  assign vsync = vs_level;
endmodule

// *** testbench/smd_front_end_tb_top.sv ***
// Purpose: Self-checking bench for the sync mode detection front end.
// Assumes: Line period of 200 clocks, so four lines count 800 ticks, or 400 when halved.
// Notes: Reads queue their expected word; a monitor compares the answer.
module smd_front_end_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, hs, vs, wr, rd, run, neg, vsl, rd_q;
  logic hsync_out, vsync_out, vsep_out, mode_irq;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, lfsr;
  logic [11:0] period;
  logic [15:0] exp_q[$], tol_q[$], msk_q[$];
  int errors, checks_done;

  smd_host_model host (.clk(clk), .run(run), .neg(neg), .period(period),
    .vs_level(vsl), .hsync(hs), .vsync(vs));
  smd_front_end dut (.clk(clk), .arst_n(arst_n), .hsync_pin(hs), .vsync_pin(vs),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .hsync_out(hsync_out), .vsync_out(vsync_out), .vsep_out(vsep_out),
    .mode_irq(mode_irq));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] e, input logic [15:0] t);
    checks_done++;
    if (!((got + t >= e && got <= e + t) === 1'b1))
      fail($sformatf("read %h expected %h", got, e));
  endtask

  task automatic cmp_bit(input logic got, input logic e, input string m);
    checks_done++;
    if (got !== e)
      fail(m);
  endtask

  task automatic end_of_test;
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [1:0] a, input logic [15:0] e, input logic [15:0] t,
    input logic [15:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    tol_q.push_back(t);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic wait_irq(input int n);
    int i;
    i = 0;
    while (mode_irq !== 1'b1 && i < n)
    begin
      @(posedge clk);
      i++;
    end
    cmp_bit(mode_irq, 1'b1, "interrupt missing");
  endtask

  task automatic hold_low(input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (mode_irq !== 1'b0)
        bad = 1;
    end
    cmp_bit(bad[0], 1'b0, "interrupt too early");
  endtask

  always @(posedge clk)
    rd_q <= rd;

  // Read data stand only in the cycle after the strobe.
  always @(negedge clk)
  begin
    if (rd_q === 1'b1)
      cmp_word(rdata & msk_q.pop_front(), exp_q.pop_front(), tol_q.pop_front());
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #(100000 * 25);
    fail("watchdog expired");
    end_of_test();
  end

  initial
  begin
    {arst_n, wr, rd, run, neg, vsl} = '0;
    addr = 2'h0;
    wdata = 16'h0000;
    period = 12'h0C8;
    lfsr = 16'h0001;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(smd_pkg::REG_STATUS, 16'h0002, 16'h0000, 16'hFFFF);
    rd_reg(smd_pkg::REG_CTRL, 16'h0000, 16'h0000, 16'hFFFF);
    rd_reg(smd_pkg::REG_HPER, 16'h0000, 16'h0000, 16'hFFFF);
    wait_irq(5000);
    cmp_bit(vsep_out, 1'b0, "separated sync without composite");
    for (int k = 0; k < 2; k++)
    begin
      lfsr = lfsr_next(lfsr);
      wr_reg(smd_pkg::REG_STATUS + 2'(k), lfsr);
    end
    rd_reg(smd_pkg::REG_HPER, 16'h0000, 16'h0000, 16'hFFFF);
    rd_reg(smd_pkg::REG_STATUS, 16'h0022, 16'h0000, 16'h0022);
    wr_reg(smd_pkg::REG_CTRL, 16'h0004);
    repeat (2) @(posedge clk);
    cmp_bit(mode_irq, 1'b0, "ack ignored");
    run <= 1'b1;
    wait_irq(12000);
    repeat (4000) @(posedge clk);
    rd_reg(smd_pkg::REG_HPER, 16'd800, 16'h0002, 16'hFFFF);
    rd_reg(smd_pkg::REG_STATUS, 16'h0000, 16'h0000, 16'h0002);
    wr_reg(smd_pkg::REG_CTRL, 16'h0006);
    hold_low(8000);
    wait_irq(8000);
    repeat (4000) @(posedge clk);
    rd_reg(smd_pkg::REG_HPER, 16'd400, 16'h0002, 16'hFFFF);
    rd_reg(smd_pkg::REG_CTRL, 16'h0002, 16'h0000, 16'hFFFF);
    wr_reg(smd_pkg::REG_CTRL, 16'h0006);
    neg <= 1'b1;
    hold_low(9000);
    wait_irq(6000);
    rd_reg(smd_pkg::REG_STATUS, 16'h0001, 16'h0000, 16'h0001);
    @(negedge hs);
    repeat (12) @(posedge clk);
    cmp_bit(hsync_out, 1'b1, "corrected pulse not high");
    repeat (100) @(posedge clk);
    cmp_bit(hsync_out, 1'b0, "corrected line not low");
    wr_reg(smd_pkg::REG_CTRL, 16'h0006);
    vsl <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_bit(vsync_out, 1'b1, "pin vertical sync high");
    vsl <= 1'b0;
    repeat (8) @(posedge clk);
    cmp_bit(vsync_out, 1'b0, "pin vertical sync low");
    wr_reg(smd_pkg::REG_CTRL, 16'h0003);
    repeat (800) @(posedge clk);
    cmp_bit(vsep_out, 1'b1, "separated level");
    cmp_bit(vsync_out, 1'b1, "separated source");
    run <= 1'b0;
    wait_irq(9000);
    repeat (4) @(posedge clk);
    cmp_bit(vsep_out, 1'b0, "separated sync after loss");
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
